// *** hdl/ecta_aux.v ***
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`include "ecta_map.vh"
// Summary of operation
// [R1] Timer clock: prescaler, accumulator clock, /256 or /65536
// [R2] Cascade A off forces prescaler clock; new selection applies at once
// [R3] Overflow and edge flags request interrupts only while enabled
// [R4] Fast clear: access to cascade A count clears all A flags
// [R5] A overflow sets on cascade or upper byte wrap; write one bit 1 clears
// [R6] Edge flag sets on event edge or trailing gate edge; bit 0 clears
// [R7] Cascaded pairs count as one; high byte carry of B flags overflow
// [R8] Software accesses each 16-bit count as one word; the cascade counts here are separate byte registers ACC3/ACC2 and ACC1/ACC0
// [R9] One-shot stops at zero; modulus mode reloads latest written value
// [R10] Software disables down-counter before changing mode
// [R11] Count read returns count, or load register when select set
// [R12] Force latch moves captures, accumulators to holding; clears them
// [R13] Force load, while enabled, loads count and resets prescaler
// [R14] Disabled down-counter held at FFFF
// [R15] Prescaler 1, 4, 8, 16; new rate applies at next load
// [R16] Underflow flag at zero; cleared by bit 7 write or fast access; bit 7 write is ignored while fast clear is on
// [R17] Read-only polarity bits record first capture edge after holding read
// [R18] Single enables act only while their cascade is off
// [R19] Delay filter waits 256/512/1024 clocks, pulses if level changed
// [R20] No-overwrite keeps full capture and holding registers
// [R21] System register writable once in normal mode, always in special
// [R22] Sharing lets a channel's pin trigger its pair
// [R23] Gated mode counts clock divided by 64 at the chosen level
// [R24] Down-counter decrements per prescaler tick, stays at zero in one-shot
module ecta_aux (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [7:0] capture_pin,
  input wire presc_tick,
  input wire [15:0] timer_count,
  input wire special_mode_n,
  input wire [3:0] capture_read,
  input wire [3:0] holding_read,
  output reg timer_clock_tick,
  output reg accum_a_overflow_irq,
  output reg input_edge_irq,
  output reg underflow_irq,
  output reg cascade_b_overflow_pulse,
  output reg [7:0] capture_event,
  output reg [63:0] capture_data,
  output reg [63:0] holding_data,
  output reg [31:0] holding_accum
);
  reg [6:0] actl_reg;
  reg [1:0] aflg_reg;
  reg [7:0] acc_reg [0:3];
  reg [7:0] dctl_reg;
  reg dflg_reg;
  reg [3:0] polf_reg;
  reg [3:0] sen_reg;
  reg [1:0] dly_reg;
  reg [7:0] novw_reg;
  reg [7:0] sys_reg;
  reg sys_done_reg;
  reg [1:0] opt_reg;
  reg [15:0] dload_reg;
  reg [15:0] dcnt_reg;
  reg [3:0] dpre_reg;
  reg [3:0] drate_reg;
  reg [15:0] adiv_reg;
  reg [5:0] div64_reg;
  reg [7:0] sync1_reg;
  reg [7:0] sync2_reg;
  reg [7:0] prev_reg;
  reg [7:0] filt_reg;
  reg [7:0] flvl_reg;
  reg [3:0] cap_empty_reg;
  reg [3:0] hold_empty_reg;
  reg [3:0] arm_reg;
  reg [31:0] rdata_next;
  reg known_next;
  reg [3:0] rate_next;
  reg [15:0] acc32_next;
  reg [15:0] acc10_next;
  integer k;

  wire [7:0] idx = paddr[9:2];
  wire addr_ok = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  wire access = psel && penable && pready;
  wire wr = access && pwrite && !pslverr;
  wire rd = access && !pwrite && !pslverr;
  wire acc_any = wr || rd;
  wire ffc = opt_reg[`ECTA_OPT_FFC];
  wire casc_a = actl_reg[`ECTA_ACTL_EN];
  wire casc_b = opt_reg[`ECTA_OPT_BEN];
  wire gated = actl_reg[`ECTA_ACTL_MODE];
  wire pedge = actl_reg[`ECTA_ACTL_EDGE];
  wire dc_en = dctl_reg[`ECTA_DCTL_EN];
  wire latch_mode = sys_reg[`ECTA_SYS_HOLD] && sys_reg[`ECTA_SYS_LATCH_OR_QUEUE];
  wire queue_mode = sys_reg[`ECTA_SYS_HOLD] && !sys_reg[`ECTA_SYS_LATCH_OR_QUEUE];
  wire satur = sys_reg[`ECTA_SYS_SATUR];
  wire [7:0] rise = sync2_reg & ~prev_reg;
  wire [7:0] fall = ~sync2_reg & prev_reg;
  wire [7:0] edge_any = rise | fall;

  // Cascade A input on the shared pin
  wire pin_edge = pedge ? rise[7] : fall[7]; // R6
  wire gate_open = (sync2_reg[7] == !pedge); // R23
  wire gate_tick = gate_open && (div64_reg == 6'h3f); // R23
  wire accum_tick = casc_a && (gated ? gate_tick : pin_edge);
  wire div256_tick = accum_tick && (adiv_reg[7:0] == 8'hff); // R1
  wire div64k_tick = accum_tick && (adiv_reg == 16'hffff); // R1

  // Individual accumulator increments
  wire [3:0] inc_single;
  assign inc_single[3] = !casc_a && sen_reg[3] && filt_reg[3]; // R18
  assign inc_single[2] = !casc_a && sen_reg[2] && filt_reg[2]; // R18
  assign inc_single[1] = !casc_b && sen_reg[1] && filt_reg[1]; // R18
  assign inc_single[0] = !casc_b && sen_reg[0] && filt_reg[0]; // R18
  wire inc_b = casc_b && filt_reg[0];
  wire [15:0] casc_a_val = {acc_reg[3], acc_reg[2]};
  wire [15:0] casc_b_val = {acc_reg[1], acc_reg[0]};
  wire wrap3 = inc_single[3] && !satur && (acc_reg[3] == 8'hff);
  wire ovf_a = (accum_tick && casc_a_val == 16'hffff) || wrap3; // R5
  wire wrap1 = inc_single[1] && !satur && (acc_reg[1] == 8'hff);
  wire ovf_b = (inc_b && casc_b_val == 16'hffff) || wrap1; // R7

  // Down-counter control events
  wire wr_dctl = wr && (idx == `ECTA_IDX_DCTL);
  wire wr_dcnt = wr && (idx == `ECTA_IDX_DCNT);
  wire force_load = wr_dctl && pwdata[`ECTA_DCTL_FLOAD] && dc_en; // R13
  wire load_now = force_load || (wr_dcnt && dc_en);
  wire dtick = dc_en && (dpre_reg == drate_reg);
  wire reach_zero = dc_en && !load_now && dtick && (dcnt_reg == 16'h0001);
  wire reload = dc_en && !load_now && dtick && (dcnt_reg == 16'h0000) &&
    dctl_reg[`ECTA_DCTL_MODE];
  wire force_latch = wr_dctl && pwdata[`ECTA_DCTL_LATCH];
  wire latch_now = latch_mode && (force_latch || reach_zero ||
    (wr_dcnt && pwdata[15:0] == 16'h0000)); // R12

  // Read mux
  always @* begin
    rdata_next = 32'h0000_0000;
    known_next = 1'b1;
    case (idx)
      `ECTA_IDX_ACTL: rdata_next[6:0] = actl_reg;
      `ECTA_IDX_AFLG: rdata_next[1:0] = aflg_reg;
      `ECTA_IDX_ACC3: rdata_next[7:0] = acc_reg[3];
      `ECTA_IDX_ACC2: rdata_next[7:0] = acc_reg[2];
      `ECTA_IDX_ACC1: rdata_next[7:0] = acc_reg[1];
      `ECTA_IDX_ACC0: rdata_next[7:0] = acc_reg[0];
      `ECTA_IDX_DCTL: rdata_next[7:0] = {dctl_reg[7:5], 2'b00, dctl_reg[2:0]};
      `ECTA_IDX_DFLG: rdata_next[7:0] = {dflg_reg, 3'b000, polf_reg}; // R17
      `ECTA_IDX_SEN: rdata_next[3:0] = sen_reg;
      `ECTA_IDX_DLY: rdata_next[1:0] = dly_reg;
      `ECTA_IDX_NOVW: rdata_next[7:0] = novw_reg;
      `ECTA_IDX_SYS: rdata_next[7:0] = sys_reg;
      `ECTA_IDX_DCNT: rdata_next[15:0] =
        dctl_reg[`ECTA_DCTL_RDSEL] ? dload_reg : dcnt_reg; // R11
      `ECTA_IDX_OPT: rdata_next[1:0] = opt_reg;
      default: known_next = 1'b0;
    endcase
    if (!addr_ok) begin
      known_next = 1'b0;
      rdata_next = 32'h0000_0000;
    end
  end

  // APB answer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !known_next;
      prdata <= (psel && !penable && !pwrite && known_next) ?
        rdata_next : 32'h0000_0000;
    end
  end

  // Control registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      actl_reg <= 7'h00;
      dctl_reg <= `ECTA_RST_8;
      sen_reg <= 4'h0;
      dly_reg <= 2'b00;
      novw_reg <= `ECTA_RST_8;
      sys_reg <= `ECTA_RST_8;
      sys_done_reg <= 1'b0;
      opt_reg <= 2'b00;
    end else if (wr) begin
      if (idx == `ECTA_IDX_ACTL)
        actl_reg <= pwdata[6:0];
      if (idx == `ECTA_IDX_DCTL)
        dctl_reg <= {pwdata[7:5], 2'b00, pwdata[2:0]}; // R12 R13
      if (idx == `ECTA_IDX_SEN)
        sen_reg <= pwdata[3:0];
      if (idx == `ECTA_IDX_DLY)
        dly_reg <= pwdata[1:0];
      if (idx == `ECTA_IDX_NOVW)
        novw_reg <= pwdata[7:0];
      if (idx == `ECTA_IDX_OPT)
        opt_reg <= pwdata[1:0];
      if (idx == `ECTA_IDX_SYS && (!sys_done_reg || !special_mode_n)) begin
        sys_reg <= pwdata[7:0]; // R21
        sys_done_reg <= special_mode_n; // R21
      end
    end
  end

  // Cascade A flags, set wins over clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aflg_reg <= 2'b00;
    end else begin
      if (ffc && acc_any &&
          (idx == `ECTA_IDX_ACC3 || idx == `ECTA_IDX_ACC2))
        aflg_reg <= 2'b00; // R4
      else if (wr && idx == `ECTA_IDX_AFLG)
        aflg_reg <= aflg_reg & ~pwdata[1:0]; // R5 R6
      if (ovf_a)
        aflg_reg[`ECTA_AFLG_OVF] <= 1'b1; // R5
      if (casc_a && pin_edge)
        aflg_reg[`ECTA_AFLG_EDGE] <= 1'b1; // R6
    end
  end

  // Pulse accumulators
  always @* begin
    acc32_next = casc_a_val + 16'h0001;
    acc10_next = casc_b_val + 16'h0001;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (k = 0; k < 4; k = k + 1)
        acc_reg[k] <= `ECTA_RST_8;
    end else if (latch_now) begin
      for (k = 0; k < 4; k = k + 1)
        acc_reg[k] <= 8'h00; // R12
    end else begin
      if (accum_tick) begin
        acc_reg[3] <= acc32_next[15:8]; // R7
        acc_reg[2] <= acc32_next[7:0]; // R7
      end
      if (inc_b) begin
        acc_reg[1] <= acc10_next[15:8]; // R7
        acc_reg[0] <= acc10_next[7:0]; // R7
      end
      for (k = 0; k < 4; k = k + 1)
        if (inc_single[k] && !(satur && acc_reg[k] == 8'hff))
          acc_reg[k] <= acc_reg[k] + 8'h01; // R18
      if (wr && idx == `ECTA_IDX_ACC3)
        acc_reg[3] <= pwdata[7:0];
      if (wr && idx == `ECTA_IDX_ACC2)
        acc_reg[2] <= pwdata[7:0];
      if (wr && idx == `ECTA_IDX_ACC1)
        acc_reg[1] <= pwdata[7:0];
      if (wr && idx == `ECTA_IDX_ACC0)
        acc_reg[0] <= pwdata[7:0];
    end
  end

  // Timer counter clock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div64_reg <= 6'h00;
      adiv_reg <= 16'h0000;
      timer_clock_tick <= 1'b0;
      cascade_b_overflow_pulse <= 1'b0;
      accum_a_overflow_irq <= 1'b0;
      input_edge_irq <= 1'b0;
      underflow_irq <= 1'b0;
    end else begin
      div64_reg <= div64_reg + 6'h01; // R23
      if (accum_tick)
        adiv_reg <= adiv_reg + 16'h0001;
      if (!casc_a)
        timer_clock_tick <= presc_tick; // R2
      else begin
        case (actl_reg[3:2])
          2'b00: timer_clock_tick <= presc_tick; // R1
          2'b01: timer_clock_tick <= accum_tick; // R1
          2'b10: timer_clock_tick <= div256_tick; // R1
          default: timer_clock_tick <= div64k_tick; // R1
        endcase
      end
      cascade_b_overflow_pulse <= ovf_b; // R7
      accum_a_overflow_irq <= aflg_reg[`ECTA_AFLG_OVF] && actl_reg[1]; // R3
      input_edge_irq <= aflg_reg[`ECTA_AFLG_EDGE] && actl_reg[0]; // R3
      underflow_irq <= dflg_reg && dctl_reg[`ECTA_DCTL_ZI];
    end
  end

  // Modulus down-counter
  always @* begin
    case (wr_dctl ? pwdata[1:0] : dctl_reg[1:0])
      2'b00: rate_next = `ECTA_PR_1; // R15
      2'b01: rate_next = `ECTA_PR_4; // R15
      2'b10: rate_next = `ECTA_PR_8; // R15
      default: rate_next = `ECTA_PR_16; // R15
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dload_reg <= 16'h0000;
      dcnt_reg <= `ECTA_RST_DCNT;
      dpre_reg <= 4'h0;
      drate_reg <= `ECTA_PR_1;
      dflg_reg <= 1'b0;
    end else begin
      if (wr_dcnt)
        dload_reg <= pwdata[15:0];
      if (!dc_en) begin
        dcnt_reg <= `ECTA_RST_DCNT; // R14
        dpre_reg <= 4'h0;
      end else if (load_now) begin
        dcnt_reg <= wr_dcnt ? pwdata[15:0] : dload_reg; // R13
        dpre_reg <= 4'h0; // R13
        drate_reg <= rate_next; // R15
      end else if (dtick) begin
        dpre_reg <= 4'h0;
        if (dcnt_reg != 16'h0000)
          dcnt_reg <= dcnt_reg - 16'h0001; // R24
        else if (reload) begin
          dcnt_reg <= dload_reg; // R9
          drate_reg <= rate_next; // R15
        end
      end else
        dpre_reg <= dpre_reg + 4'h1; // R24
      if (ffc && acc_any && idx == `ECTA_IDX_DCNT)
        dflg_reg <= 1'b0; // R16
      else if (!ffc && wr && idx == `ECTA_IDX_DFLG &&
               pwdata[`ECTA_DFLG_UF])
        dflg_reg <= 1'b0; // R16
      if (reach_zero)
        dflg_reg <= 1'b1; // R16
    end
  end

  // Pin synchronisers and edge delay filters
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
      prev_reg <= 8'h00;
    end else begin
      sync1_reg <= capture_pin;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : dly
      reg busy_reg;
      reg before_reg;
      reg [10:0] cnt_reg;
      wire [10:0] len = (dly_reg == 2'b01) ? `ECTA_DLY_256 :
        (dly_reg == 2'b10) ? `ECTA_DLY_512 : `ECTA_DLY_1024;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          busy_reg <= 1'b0;
          before_reg <= 1'b0;
          cnt_reg <= 11'h000;
          filt_reg[g] <= 1'b0;
          flvl_reg[g] <= 1'b0;
        end else begin
          filt_reg[g] <= 1'b0;
          if (busy_reg) begin
            cnt_reg <= cnt_reg + 11'h001; // R19
            if (cnt_reg == len) begin
              busy_reg <= 1'b0; // R19
              cnt_reg <= 11'h000; // R19
              filt_reg[g] <= (sync2_reg[g] != before_reg); // R19
              flvl_reg[g] <= sync2_reg[g];
            end
          end else if (edge_any[g]) begin
            if (dly_reg == 2'b00) begin
              filt_reg[g] <= 1'b1; // R19
              flvl_reg[g] <= sync2_reg[g];
            end else begin
              busy_reg <= 1'b1; // R19
              before_reg <= prev_reg[g]; // R19
              cnt_reg <= 11'h000;
            end
          end
        end
      end
    end
  endgenerate

  // Capture actions
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      capture_event <= 8'h00;
    else begin
      capture_event[3:0] <= filt_reg[3:0];
      for (k = 0; k < 4; k = k + 1)
        capture_event[k + 4] <= sys_reg[k + 4] ? filt_reg[k] :
          filt_reg[k + 4]; // R22
    end
  end

  // Capture and holding registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_data <= 64'h0000_0000_0000_0000;
      holding_data <= 64'h0000_0000_0000_0000;
      holding_accum <= 32'h0000_0000;
      cap_empty_reg <= 4'hf;
      hold_empty_reg <= 4'hf;
      arm_reg <= 4'hf;
      polf_reg <= 4'h0;
    end else begin
      for (k = 0; k < 4; k = k + 1) begin
        if (capture_read[k])
          cap_empty_reg[k] <= 1'b1;
        if (holding_read[k]) begin
          hold_empty_reg[k] <= 1'b1;
          arm_reg[k] <= 1'b1; // R17
        end
        if (latch_now) begin
          holding_accum[k*8 +: 8] <= acc_reg[k]; // R12
          if (!(novw_reg[k] && !hold_empty_reg[k])) begin
            holding_data[k*16 +: 16] <= capture_data[k*16 +: 16]; // R12 R20
            hold_empty_reg[k] <= 1'b0;
            cap_empty_reg[k] <= 1'b1; // R20
          end
        end else if (filt_reg[k] &&
                     !(novw_reg[k] && !cap_empty_reg[k])) begin
          capture_data[k*16 +: 16] <= timer_count; // R20
          cap_empty_reg[k] <= 1'b0;
          if (queue_mode &&
              !(novw_reg[k] && !hold_empty_reg[k])) begin
            holding_data[k*16 +: 16] <= capture_data[k*16 +: 16]; // R20
            hold_empty_reg[k] <= 1'b0;
          end
          if (arm_reg[k]) begin
            polf_reg[k] <= flvl_reg[k]; // R17
            arm_reg[k] <= 1'b0; // R17
          end
        end
      end
    end
  end

endmodule // ecta_aux

// *** hdl/ecta_map.vh ***
`ifndef ECTA_MAP_VH
`define ECTA_MAP_VH
// Register indices; byte address is four times the index
`define ECTA_IDX_ACTL 8'ha0
`define ECTA_IDX_AFLG 8'ha1
`define ECTA_IDX_ACC3 8'ha2
`define ECTA_IDX_ACC2 8'ha3
`define ECTA_IDX_ACC1 8'ha4
`define ECTA_IDX_ACC0 8'ha5
`define ECTA_IDX_DCTL 8'ha6
`define ECTA_IDX_DFLG 8'ha7
`define ECTA_IDX_SEN 8'ha8
`define ECTA_IDX_DLY 8'ha9
`define ECTA_IDX_NOVW 8'haa
`define ECTA_IDX_SYS 8'hab
`define ECTA_IDX_DCNT 8'hc0
`define ECTA_IDX_OPT 8'hc1
// Field positions
`define ECTA_ACTL_EN 6
`define ECTA_ACTL_MODE 5
`define ECTA_ACTL_EDGE 4
`define ECTA_AFLG_OVF 1
`define ECTA_AFLG_EDGE 0
`define ECTA_DCTL_ZI 7
`define ECTA_DCTL_MODE 6
`define ECTA_DCTL_RDSEL 5
`define ECTA_DCTL_LATCH 4
`define ECTA_DCTL_FLOAD 3
`define ECTA_DCTL_EN 2
`define ECTA_DFLG_UF 7
`define ECTA_SYS_SATUR 2
`define ECTA_SYS_HOLD 1
`define ECTA_SYS_LATCH_OR_QUEUE 0
`define ECTA_OPT_FFC 0
`define ECTA_OPT_BEN 1
// Reset values
`define ECTA_RST_8 8'h00
`define ECTA_RST_DCNT 16'hffff
// Edge delay lengths in module clocks, minus one
`define ECTA_DLY_256 11'h0ff
`define ECTA_DLY_512 11'h1ff
`define ECTA_DLY_1024 11'h3ff
// Prescaler terminal counts
`define ECTA_PR_1 4'h0
`define ECTA_PR_4 4'h3
`define ECTA_PR_8 4'h7
`define ECTA_PR_16 4'hf
`endif

// *** test/ecta_aux_chk.sv ***
`timescale 1ns/1ps
`include "ecta_map.vh"
module ecta_aux_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire special_mode_n,
  input wire presc_tick,
  input wire timer_clock_tick,
  input wire accum_a_overflow_irq,
  input wire input_edge_irq,
  input wire underflow_irq,
  input wire cascade_b_overflow_pulse,
  input wire [7:0] capture_event
);
  wire acc = psel & penable & pready;
  wire [7:0] idx = paddr[9:2];
  wire [7:0] wi = (acc & pwrite) ? idx : 8'h00;
  reg [7:0] actl_reg;
  reg en_reg, rdsel_reg, ffc_reg, share_reg, sys_done_reg;
  reg [1:0] off_reg, stab_reg;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Control bits that the properties depend on
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      actl_reg <= 8'h00;
      {en_reg, rdsel_reg, ffc_reg, share_reg, sys_done_reg} <= 5'h00;
      off_reg <= 2'h0;
      stab_reg <= 2'h0;
    end else begin
      if (wi == `ECTA_IDX_ACTL) actl_reg <= pwdata[7:0];
      if (wi == `ECTA_IDX_DCTL) {rdsel_reg, en_reg} <= {pwdata[5], pwdata[2]};
      if (wi == `ECTA_IDX_OPT) ffc_reg <= pwdata[0];
      if (wi == `ECTA_IDX_SYS) begin
        sys_done_reg <= 1'b1;
        if (!sys_done_reg || !special_mode_n) share_reg <= pwdata[4];
      end
      off_reg <= en_reg ? 2'h0 : (off_reg == 2'h3 ? off_reg : off_reg + 2'h1);
      if (wi == `ECTA_IDX_ACTL || (actl_reg[6] && actl_reg[3:2] != 2'h0))
        stab_reg <= 2'h0;
      else if (stab_reg != 2'h2) stab_reg <= stab_reg + 2'h1;
    end
  end
  property p_ovf_ie_off;
    wi == `ECTA_IDX_ACTL && !pwdata[1] |=> ##1 !accum_a_overflow_irq;
  endproperty
  a_ovf_ie_off: assert property (p_ovf_ie_off) else $error("ovf irq set");
  property p_edge_ie_off;
    wi == `ECTA_IDX_ACTL && !pwdata[0] |=> ##1 !input_edge_irq;
  endproperty
  a_edge_ie_off: assert property (p_edge_ie_off) else $error("edge irq set");
  property p_ovf_clr;
    wi == `ECTA_IDX_AFLG && pwdata[1] |=> ##1 !accum_a_overflow_irq;
  endproperty
  a_ovf_clr: assert property (p_ovf_clr) else $error("ovf kept");
  property p_edge_clr;
    wi == `ECTA_IDX_AFLG && pwdata[0] |=> ##1 !input_edge_irq;
  endproperty
  a_edge_clr: assert property (p_edge_clr) else $error("edge kept");
  property p_fast_clr;
    acc && ffc_reg && (idx == `ECTA_IDX_ACC3 || idx == `ECTA_IDX_ACC2)
      |=> ##1 !accum_a_overflow_irq && !input_edge_irq;
  endproperty
  a_fast_clr: assert property (p_fast_clr) else $error("fast clear missed");
  property p_uf_clr;
    wi == `ECTA_IDX_DFLG && pwdata[7] && !ffc_reg |=> ##1 !underflow_irq;
  endproperty
  a_uf_clr: assert property (p_uf_clr) else $error("underflow kept");
  property p_strobe_zero;
    acc && !pwrite && idx == `ECTA_IDX_DCTL |-> prdata[4:3] == 2'h0;
  endproperty
  a_strobe_zero: assert property (p_strobe_zero) else $error("strobe read one");
  property p_hold_ffff;
    acc && !pwrite && idx == `ECTA_IDX_DCNT && off_reg == 2'h3 && !rdsel_reg
      |-> prdata[15:0] == 16'hffff;
  endproperty
  a_hold_ffff: assert property (p_hold_ffff) else $error("idle count");
  property p_tclk;
    stab_reg == 2'h2 |-> timer_clock_tick == $past(presc_tick);
  endproperty
  a_tclk: assert property (p_tclk) else $error("timer clock");
  property p_share;
    share_reg && $past(share_reg) |-> capture_event[4] == capture_event[0];
  endproperty
  a_share: assert property (p_share) else $error("share differs");
  c_bov: cover property (cascade_b_overflow_pulse);
  c_share: cover property (share_reg && capture_event[4]);
  c_uf: cover property (underflow_irq);
  c_ovf: cover property (accum_a_overflow_irq && input_edge_irq);
endmodule // ecta_aux_chk
bind ecta_aux ecta_aux_chk ecta_aux_chk_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .special_mode_n(special_mode_n), .presc_tick(presc_tick),
  .timer_clock_tick(timer_clock_tick),
  .accum_a_overflow_irq(accum_a_overflow_irq),
  .input_edge_irq(input_edge_irq), .underflow_irq(underflow_irq),
  .cascade_b_overflow_pulse(cascade_b_overflow_pulse),
  .capture_event(capture_event));

// *** test/ecta_pins.sv ***
`timescale 1ns/1ps
module ecta_pins (
  input wire pclk,
  input wire presetn,
  input wire [7:0] pin_set,
  output reg [7:0] capture_pin,
  output reg presc_tick,
  output reg [15:0] timer_count
);
  reg [1:0] div_reg;
  // Pins follow the requested levels; prescaler ticks every fourth clock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_pin <= 8'h00;
      presc_tick <= 1'b0;
      timer_count <= 16'h0000;
      div_reg <= 2'h0;
    end else begin
      capture_pin <= pin_set;
      div_reg <= div_reg + 2'h1;
      presc_tick <= (div_reg == 2'h3);
      if (presc_tick) timer_count <= timer_count + 16'h0001;
    end
  end
endmodule // ecta_pins

// *** test/test_capture_timer_accumulator_modulus.sv ***
`timescale 1ns/1ps
`include "ecta_map.vh"
module test_capture_timer_accumulator_modulus;
  reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0000_0000;
  reg special_mode_n = 1'b1;
  reg [7:0] pin_set = 8'h00;
  wire [31:0] prdata, holding_accum;
  wire pready, pslverr, presc_tick, timer_clock_tick, underflow_irq;
  wire accum_a_overflow_irq, input_edge_irq, cascade_b_overflow_pulse;
  wire [7:0] capture_pin, capture_event;
  wire [15:0] timer_count;
  wire [63:0] capture_data, holding_data;
  reg [31:0] rdat, c1;
  reg rerr;
  int errors = 0, compares = 0, ev1 = 0, ev4 = 0, bov = 0, m = 0;
  always #20 pclk = ~pclk;
  ecta_pins ecta_pins_i (.pclk(pclk), .presetn(presetn), .pin_set(pin_set),
    .capture_pin(capture_pin), .presc_tick(presc_tick),
    .timer_count(timer_count));
  ecta_aux ecta_aux_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_pin(capture_pin), .presc_tick(presc_tick),
    .timer_count(timer_count), .special_mode_n(special_mode_n),
    .capture_read(4'h0), .holding_read(4'h0),
    .timer_clock_tick(timer_clock_tick),
    .accum_a_overflow_irq(accum_a_overflow_irq),
    .input_edge_irq(input_edge_irq), .underflow_irq(underflow_irq),
    .cascade_b_overflow_pulse(cascade_b_overflow_pulse),
    .capture_event(capture_event), .capture_data(capture_data),
    .holding_data(holding_data), .holding_accum(holding_accum));
  always @(posedge pclk) begin
    if (capture_event[1]) ev1 <= ev1 + 1;
    if (capture_event[4]) ev4 <= ev4 + 1;
    if (cascade_b_overflow_pulse) bov <= bov + 1;
  end
  task summarize;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input [7:0] i, input w, input [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n = n + 1;
      @(posedge pclk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(n < 20, 1);
  endtask
  task wr(input [7:0] i, input [31:0] d);
    apb(i, 1'b1, d);
  endtask
  task rd(input [7:0] i);
    apb(i, 1'b0, 32'h0000_0000);
  endtask
  task rdc(input [7:0] i, input [15:0] e);
    rd(i);
    chk(rdat, {16'h0000, e});
  endtask
  task tog(input int ch);
    @(posedge pclk);
    pin_set[ch] <= ~pin_set[ch];
    repeat (12) @(posedge pclk);
  endtask
  task t_reset;
    for (int i = 8'ha0; i <= 8'hab; i++)
      rdc(i[7:0], 16'h0000);
    rdc(`ECTA_IDX_OPT, 16'h0000);
    rdc(`ECTA_IDX_DCNT, 16'hffff);
    rd(8'h10);
    chk(rerr, 1);
  endtask
  task t_down;
    wr(`ECTA_IDX_DCTL, 32'h0000_0004);
    wr(`ECTA_IDX_DCNT, 32'h0000_0005);
    repeat (20) @(posedge pclk);
    rdc(`ECTA_IDX_DCNT, 16'h0000);
    rd(`ECTA_IDX_DFLG);
    chk(rdat[7], 1);
    wr(`ECTA_IDX_DFLG, 32'h0000_0080);
    rd(`ECTA_IDX_DFLG);
    chk(rdat[7], 0);
    rdc(`ECTA_IDX_DCTL, 16'h0004);
    wr(`ECTA_IDX_DCTL, 32'h0000_0024);
    rdc(`ECTA_IDX_DCNT, 16'h0005);
    wr(`ECTA_IDX_DCTL, 32'h0000_0000);
    rdc(`ECTA_IDX_DCNT, 16'hffff);
    wr(`ECTA_IDX_DCNT, 32'h0000_0003);
    wr(`ECTA_IDX_DCTL, 32'h0000_0007);
    wr(`ECTA_IDX_DCTL, 32'h0000_000f);
    repeat (20) @(posedge pclk);
    rd(`ECTA_IDX_DCNT);
    chk(rdat == 0, 0);
    repeat (60) @(posedge pclk);
    rdc(`ECTA_IDX_DCNT, 16'h0000);
    wr(`ECTA_IDX_DCTL, 32'h0000_0000);
    wr(`ECTA_IDX_DCTL, 32'h0000_00c7);
    wr(`ECTA_IDX_DCTL, 32'h0000_00cf);
    repeat (100) @(posedge pclk);
    rd(`ECTA_IDX_DCNT);
    c1 = rdat;
    repeat (20) @(posedge pclk);
    rd(`ECTA_IDX_DCNT);
    chk({c1 <= 3, rdat <= 3, (c1 | rdat) != 0}, 3'h7);
    chk(underflow_irq, 1);
    wr(`ECTA_IDX_DCTL, 32'h0000_0000);
  endtask
  task t_accum;
    wr(`ECTA_IDX_SEN, 32'h0000_0001);
    repeat (3) tog(0);
    rdc(`ECTA_IDX_ACC0, 16'h0003);
    rdc(`ECTA_IDX_ACC1, 16'h0000);
    wr(`ECTA_IDX_OPT, 32'h0000_0002);
    wr(`ECTA_IDX_SEN, 32'h0000_0000);
    wr(`ECTA_IDX_ACC1, 32'h0000_00ff);
    wr(`ECTA_IDX_ACC0, 32'h0000_00ff);
    m = bov;
    tog(0);
    chk(bov - m, 1);
    rdc(`ECTA_IDX_ACC1, 16'h0000);
    wr(`ECTA_IDX_OPT, 32'h0000_0000);
  endtask
  task t_casa;
    wr(`ECTA_IDX_ACTL, 32'h0000_0053);
    wr(`ECTA_IDX_ACC3, 32'h0000_00ff);
    wr(`ECTA_IDX_ACC2, 32'h0000_00ff);
    repeat (2) tog(7);
    chk({accum_a_overflow_irq, input_edge_irq}, 2'h3);
    rdc(`ECTA_IDX_ACC3, 16'h0000);
    wr(`ECTA_IDX_AFLG, 32'h0000_0002);
    rdc(`ECTA_IDX_AFLG, 16'h0001);
    wr(`ECTA_IDX_AFLG, 32'h0000_0001);
    rdc(`ECTA_IDX_AFLG, 16'h0000);
    wr(`ECTA_IDX_ACTL, 32'h0000_0050);
    repeat (2) tog(7);
    chk(input_edge_irq, 0);
    rdc(`ECTA_IDX_AFLG, 16'h0001);
    rdc(`ECTA_IDX_ACC2, 16'h0001);
    wr(`ECTA_IDX_OPT, 32'h0000_0001);
    rd(`ECTA_IDX_ACC3);
    rdc(`ECTA_IDX_AFLG, 16'h0000);
    wr(`ECTA_IDX_OPT, 32'h0000_0000);
  endtask
  task t_sys;
    wr(`ECTA_IDX_SYS, 32'h0000_0010);
    wr(`ECTA_IDX_SYS, 32'h0000_0000);
    rdc(`ECTA_IDX_SYS, 16'h0010);
    m = ev4;
    tog(0);
    chk(ev4 - m, 1);
    chk(capture_data[15:0] != 0, 1);
    special_mode_n <= 1'b0;
    wr(`ECTA_IDX_SYS, 32'h0000_0003);
    rdc(`ECTA_IDX_SYS, 16'h0003);
    wr(`ECTA_IDX_ACC0, 32'h0000_0005);
    wr(`ECTA_IDX_DCTL, 32'h0000_0010);
    repeat (3) @(posedge pclk);
    chk(holding_accum[7:0], 8'h05);
    rdc(`ECTA_IDX_ACC0, 16'h0000);
  endtask
  task t_delay;
    wr(`ECTA_IDX_DLY, 32'h0000_0001);
    m = ev1;
    @(posedge pclk);
    pin_set[1] <= 1'b1;
    repeat (200) @(posedge pclk);
    chk(ev1 - m, 0);
    repeat (100) @(posedge pclk);
    chk(ev1 - m, 1);
  endtask
  initial begin
    #400000;
    errors = errors + 1;
    summarize;
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_down;
    t_accum;
    t_casa;
    t_sys;
    t_delay;
    summarize;
  end
endmodule // test_capture_timer_accumulator_modulus
